// [core/hwrs_pkg.sv]
package hwrs_pkg;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  // Control word fields
  localparam int CTRL_SEL     = 0;
  localparam int CTRL_STOP    = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_MODE_HI = 3;
  // Status word fields
  localparam int STAT_PD       = 3;
  localparam int STAT_TO       = 4;
  localparam int STAT_STATE_LO = 8;
  localparam int STAT_STATE_HI = 14;
  // Reset values
  localparam logic       CTRL_SEL_RST  = 1'b1;
  localparam logic       CTRL_STOP_RST = 1'b0;
  localparam logic       FLAG_RST      = 1'b1;
  // Power mode field encodings
  localparam logic [1:0] MODE_RUN  = 2'h0;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_STBY = 2'h2;
  // Timing: clock period and power-up choices in ns
  localparam longint CLK_NS     = 100;
  localparam longint PWRUP_NS_0 = 140000;
  localparam longint PWRUP_NS_1 = 4500000;
  localparam longint PWRUP_NS_2 = 18000000;
  localparam longint PWRUP_NS_3 = 72000000;
  localparam longint PWRUP_NS_4 = 288000000;
  localparam int     PWRUP_W    = 22;
  localparam logic [2:0] PWRUP_SEL_SHORT = 3'h0;
  // Oscillator cycle counts
  localparam int         OSC_W         = 10;
  localparam logic [9:0] WAKE_XTAL_CYC = 10'h200;
  localparam logic [9:0] WAKE_RC_CYC   = 10'h010;
  localparam logic [9:0] OST_SHORT_CYC = 10'h001;
  localparam logic [9:0] OST_LONG_CYC  = 10'h010;
  localparam logic [11:0] ISR_VECTOR   = 12'h008;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_PWRUP = 7'h02,
    ST_OST   = 7'h04,
    ST_RUN   = 7'h08,
    ST_STBY  = 7'h10,
    ST_HALT  = 7'h20,
    ST_WAKE  = 7'h40
  } hwrs_state_t;
endpackage

// [core/hwrs_delay_cnt.sv]
`timescale 1ns/1ps
// Down counter; done is high once the loaded number of ticks has passed
module hwrs_delay_cnt #(
  parameter int W = 22
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              done
);
  logic [W-1:0] cnt_r;

  // Load wins over counting so a restart never loses the new value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign done = (cnt_r == '0);
endmodule

// [core/hwrs_flag_unit.sv]
`timescale 1ns/1ps
// Timeout and power-down status flags, active low in meaning
module hwrs_flag_unit
  import hwrs_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic rst_take,
  input  wire logic from_halt,
  input  wire logic por_lvr,
  input  wire logic pin_rst,
  input  wire logic wdt_rst,
  input  wire logic sleep_enter,
  input  wire logic wdt_clear,
  output logic      timeout_flag,
  output logic      powerdown_flag
);
  logic to_nxt;
  logic pd_nxt;

  // Supply resets dominate, then the other reset causes, then instructions
  always_comb begin
    to_nxt = timeout_flag;
    pd_nxt = powerdown_flag;
    if (por_lvr) begin
      to_nxt = 1'b1; // [R14]
      pd_nxt = 1'b1;
    end else if (rst_take && wdt_rst) begin
      to_nxt = 1'b0; // [R15]
      pd_nxt = !from_halt;
    end else if (rst_take && pin_rst && from_halt) begin
      to_nxt = 1'b1; // [R14]
      pd_nxt = 1'b1;
    end else if (sleep_enter) begin
      to_nxt = 1'b1; // [R2]
      pd_nxt = 1'b0;
    end else if (wdt_clear) begin
      to_nxt = 1'b1; // [R15]
      pd_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timeout_flag   <= FLAG_RST;
      powerdown_flag <= FLAG_RST;
    end else begin
      timeout_flag   <= to_nxt;
      powerdown_flag <= pd_nxt;
    end
  end
endmodule

// [core/hwrs_seq.sv]
// Function
// [R1] Halt on sleep instruction or mode write 01b
// [R2] Halt entry clears power-down, sets timeout, restarts watchdog
// [R3] Halt stops core, peripherals, timers, both oscillators
// [R4] Halt wakes only on watchdog, port, external interrupt
// [R5] After halt resume normal or slow per select
// [R6] Stop bit and halt request in one write
// [R7] Software avoids mode switch together with halt
// [R8] Halt wake waits 512 crystal, else 16 cycles
// [R9] Standby wake has no stabilisation delay
// [R10] Interrupts enabled at entry: branch to 0x008
// [R11] Interrupts disabled at entry: continue next instruction
// [R12] Reset on power-on, low voltage, pin, watchdog
// [R13] Reset loads defined values, leaves others alone
// [R14] Supply and pin-from-halt resets set both flags
// [R15] Watchdog reset flags; watchdog-clear sets both flags
// [R16] Reset release starts power-up delay
// [R17] Three-bit setting picks one of five delays
// [R18] Start-up wait 1 or 16 oscillator cycles
// [R19] Reset ends in normal or slow per startup
// [R20] Standby on mode write 10b
// [R21] Wake counter counts oscillator cycles, holds execution
// [R22] Mode field returns to running on wake-up
`timescale 1ns/1ps
module hwrs_seq
  import hwrs_pkg::*;
#(
  parameter logic [PWRUP_W-1:0] PWRUP_CYC_0 = PWRUP_W'((PWRUP_NS_0 + CLK_NS - 1) / CLK_NS),
  parameter logic [PWRUP_W-1:0] PWRUP_CYC_1 = PWRUP_W'((PWRUP_NS_1 + CLK_NS - 1) / CLK_NS),
  parameter logic [PWRUP_W-1:0] PWRUP_CYC_2 = PWRUP_W'((PWRUP_NS_2 + CLK_NS - 1) / CLK_NS),
  parameter logic [PWRUP_W-1:0] PWRUP_CYC_3 = PWRUP_W'((PWRUP_NS_3 + CLK_NS - 1) / CLK_NS),
  parameter logic [PWRUP_W-1:0] PWRUP_CYC_4 = PWRUP_W'((PWRUP_NS_4 + CLK_NS - 1) / CLK_NS)
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  input  wire logic        sleep_instr,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        global_irq_enable,
  // Reset events
  input  wire logic        por_event,
  input  wire logic        low_voltage_reset,
  input  wire logic        reset_pin_n,
  input  wire logic        wdt_timeout_reset,
  // Wake sources
  input  wire logic        wdt_timeout_irq,
  input  wire logic        port_change_irq,
  input  wire logic [1:0]  external_irq_inputs,
  input  wire logic        timer_irq,
  input  wire logic        low_voltage_detect,
  // Configuration and oscillator
  input  wire logic        any_crystal_mode,
  input  wire logic [2:0]  pwrup_sel,
  input  wire logic        startup_fast,
  input  wire logic        fosc_tick,
  // Sequencer outputs
  output logic             core_reset,
  output logic             cpu_run,
  output logic             periph_en,
  output logic             timer_allow,
  output logic             hosc_en,
  output logic             losc_en,
  output logic             normal_mode,
  output logic             wdt_restart,
  output logic             resume_isr,
  output logic             resume_next,
  output logic [11:0]      isr_addr,
  output logic             timeout_flag,
  output logic             powerdown_flag
);
  hwrs_state_t state_r;
  hwrs_state_t state_nxt;

  logic             sel_r;
  logic             stop_r;
  logic [1:0]       mode_r;
  logic             gie_at_entry_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [31:0]      prdata_r;
  logic             core_reset_r;
  logic             cpu_run_r;
  logic             periph_en_r;
  logic             timer_allow_r;
  logic             hosc_en_r;
  logic             losc_en_r;
  logic             wdt_restart_r;
  logic             resume_isr_r;
  logic             resume_next_r;
  logic [11:0]      isr_addr_r;

  // Bus decode
  wire logic        apb_acc   = psel & penable;
  wire logic        apb_first = apb_acc & ~pready_r;
  wire logic        apb_done  = apb_acc & pready_r;
  wire logic        hit_ctrl  = (paddr == ADDR_CTRL);
  wire logic        hit_stat  = (paddr == ADDR_STAT);
  wire logic        wr_ctrl   = apb_done & pwrite & hit_ctrl;
  wire logic [31:0] ctrl_word = {28'h0000000, mode_r, stop_r, sel_r};
  wire logic [31:0] stat_word = {17'h00000, state_r, 3'h0, timeout_flag, powerdown_flag, 3'h0};
  wire logic [31:0] rd_mux    = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h00000000);

  // Event decode
  wire logic rst_evt   = por_event | low_voltage_reset | ~reset_pin_n | wdt_timeout_reset; // [R12]
  wire logic por_lvr   = por_event | low_voltage_reset;
  wire logic rst_take  = rst_evt & (state_r != ST_RESET);
  wire logic pwr_done;
  wire logic osc_done;
  wire logic in_halt   = (state_r == ST_HALT) | (state_r == ST_WAKE);
  wire logic halt_req  = sleep_instr | (mode_r == MODE_HALT); // [R1]
  wire logic stby_req  = (mode_r == MODE_STBY); // [R20]
  wire logic halt_wake = wdt_timeout_irq | port_change_irq | (|external_irq_inputs); // [R4]
  wire logic stby_wake = halt_wake | timer_irq | low_voltage_detect;
  wire logic go_halt   = (state_r == ST_RUN) & halt_req & ~rst_evt;
  wire logic go_stby   = (state_r == ST_RUN) & ~halt_req & stby_req & ~rst_evt;
  wire logic resume    = (state_nxt == ST_RUN) & ((state_r == ST_STBY) | (state_r == ST_WAKE));

  // Delay selection; codes above the fifth choice take the longest delay
  wire logic [PWRUP_W-1:0] pwrup_val =
    (pwrup_sel == 3'h0) ? PWRUP_CYC_0 :
    (pwrup_sel == 3'h1) ? PWRUP_CYC_1 :
    (pwrup_sel == 3'h2) ? PWRUP_CYC_2 :
    (pwrup_sel == 3'h3) ? PWRUP_CYC_3 : PWRUP_CYC_4; // [R17]
  wire logic [OSC_W-1:0] ost_val  = (pwrup_sel == PWRUP_SEL_SHORT) ? OST_SHORT_CYC : OST_LONG_CYC; // [R18]
  wire logic [OSC_W-1:0] wake_val = any_crystal_mode ? WAKE_XTAL_CYC : WAKE_RC_CYC; // [R8]
  wire logic pwr_load = (state_r == ST_RESET) & ~rst_evt; // [R16]
  wire logic osc_load = ((state_r == ST_PWRUP) & pwr_done) | ((state_r == ST_HALT) & halt_wake);
  wire logic [OSC_W-1:0] osc_val = (state_r == ST_HALT) ? wake_val : ost_val;

  // Stop bit as it will stand after this edge
  wire logic stop_nxt = rst_evt ? CTRL_STOP_RST : (wr_ctrl ? pwdata[CTRL_STOP] : stop_r);

  // Wall-clock power-up delay, counted on the system clock
  hwrs_delay_cnt #(
    .W        (PWRUP_W)
  ) u_pwrup_cnt (
    .clock    (clock),
    .nrst     (nrst),
    .load     (pwr_load),
    .load_val (pwrup_val),
    .tick     (1'b1),
    .done     (pwr_done)
  );

  // Oscillator cycles; ticks only arrive once the oscillator runs again
  hwrs_delay_cnt #(
    .W        (OSC_W)
  ) u_osc_cnt (
    .clock    (clock),
    .nrst     (nrst),
    .load     (osc_load),
    .load_val (osc_val),
    .tick     (fosc_tick), // [R21]
    .done     (osc_done)
  );

  // Status flags
  hwrs_flag_unit u_flags (
    .clock          (clock),
    .nrst           (nrst),
    .rst_take       (rst_take),
    .from_halt      (in_halt),
    .por_lvr        (por_lvr),
    .pin_rst        (~reset_pin_n),
    .wdt_rst        (wdt_timeout_reset),
    .sleep_enter    (go_halt),
    .wdt_clear      (watchdog_clear_instruction),
    .timeout_flag   (timeout_flag),
    .powerdown_flag (powerdown_flag)
  );

  // Next state; a reset event overrides every other transition
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: begin
        if (!rst_evt) state_nxt = ST_PWRUP; // [R16]
      end
      ST_PWRUP: begin
        if (pwr_done) state_nxt = ST_OST;
      end
      ST_OST: begin
        if (osc_done) state_nxt = ST_RUN; // [R18]
      end
      ST_RUN: begin
        if (halt_req) state_nxt = ST_HALT;
        else if (stby_req) state_nxt = ST_STBY;
      end
      ST_STBY: begin
        if (stby_wake) state_nxt = ST_RUN; // [R9]
      end
      ST_HALT: begin
        if (halt_wake) state_nxt = ST_WAKE; // [R4]
      end
      ST_WAKE: begin
        if (osc_done) state_nxt = ST_RUN; // [R21]
      end
      default: state_nxt = ST_RESET;
    endcase
    if (rst_evt) state_nxt = ST_RESET; // [R12]
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Control word; reset event reloads defined values only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_r  <= CTRL_SEL_RST;
      stop_r <= CTRL_STOP_RST;
    end else if (rst_evt) begin
      sel_r  <= startup_fast; // [R13] [R19]
      stop_r <= CTRL_STOP_RST;
    end else if (wr_ctrl) begin
      sel_r  <= pwdata[CTRL_SEL]; // [R6]
      stop_r <= pwdata[CTRL_STOP];
    end
  end

  // Mode field: wake-up returns it to running, so a stale request never re-enters
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_r <= MODE_RUN;
    end else if (rst_evt || resume) begin
      mode_r <= MODE_RUN; // [R22]
    end else if (go_halt) begin
      mode_r <= MODE_HALT;
    end else if (wr_ctrl) begin
      mode_r <= pwdata[CTRL_MODE_HI:CTRL_MODE_LO]; // [R1] [R20]
    end
  end

  // Interrupt enable seen at entry decides the resume path
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gie_at_entry_r <= 1'b0;
    end else if (go_halt || go_stby) begin
      gie_at_entry_r <= global_irq_enable;
    end
  end

  // APB answer: one wait state, so every answer comes from a flop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= apb_first;
      pslverr_r <= apb_first & ~hit_ctrl & ~hit_stat;
      prdata_r  <= (apb_first && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Power gating outputs; halt drops both oscillators regardless of the stop bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_reset_r  <= 1'b1;
      cpu_run_r     <= 1'b0;
      periph_en_r   <= 1'b0;
      timer_allow_r <= 1'b0;
      hosc_en_r     <= 1'b1;
      losc_en_r     <= 1'b1;
    end else begin
      core_reset_r  <= (state_nxt == ST_RESET) | (state_nxt == ST_PWRUP) | (state_nxt == ST_OST);
      cpu_run_r     <= (state_nxt == ST_RUN); // [R3] [R21]
      periph_en_r   <= (state_nxt == ST_RUN) | (state_nxt == ST_STBY); // [R3]
      timer_allow_r <= (state_nxt == ST_RUN) | (state_nxt == ST_STBY); // [R3]
      hosc_en_r     <= (state_nxt != ST_HALT) & ~(stop_nxt & (state_nxt != ST_WAKE)); // [R3] [R6]
      losc_en_r     <= (state_nxt != ST_HALT); // [R3]
    end
  end

  // One-cycle strobes to the core and watchdog
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wdt_restart_r <= 1'b0;
      resume_isr_r  <= 1'b0;
      resume_next_r <= 1'b0;
      isr_addr_r    <= ISR_VECTOR;
    end else begin
      wdt_restart_r <= go_halt; // [R2]
      resume_isr_r  <= resume & gie_at_entry_r; // [R10]
      resume_next_r <= resume & ~gie_at_entry_r; // [R11]
      isr_addr_r    <= ISR_VECTOR; // [R10]
    end
  end

  // Output wiring
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign core_reset  = core_reset_r;
  assign cpu_run     = cpu_run_r;
  assign periph_en   = periph_en_r;
  assign timer_allow = timer_allow_r;
  assign hosc_en     = hosc_en_r;
  assign losc_en     = losc_en_r;
  assign normal_mode = sel_r; // [R5] [R19]
  assign wdt_restart = wdt_restart_r;
  assign resume_isr  = resume_isr_r;
  assign resume_next = resume_next_r;
  assign isr_addr    = isr_addr_r;
endmodule

// [test/hwrs_monitor.sv]
`timescale 1ns/1ps
module hwrs_monitor
  import hwrs_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        sleep_instr,
  input wire logic        watchdog_clear_instruction,
  input wire logic        por_event,
  input wire logic        low_voltage_reset,
  input wire logic        reset_pin_n,
  input wire logic        wdt_timeout_reset,
  input wire logic        wdt_timeout_irq,
  input wire logic        port_change_irq,
  input wire logic [1:0]  external_irq_inputs,
  input wire logic        timer_irq,
  input wire logic        any_crystal_mode,
  input wire logic        fosc_tick,
  input wire logic        core_reset,
  input wire logic        cpu_run,
  input wire logic        periph_en,
  input wire logic        timer_allow,
  input wire logic        hosc_en,
  input wire logic        losc_en,
  input wire logic        wdt_restart,
  input wire logic        resume_isr,
  input wire logic        resume_next,
  input wire logic [11:0] isr_addr,
  input wire logic        timeout_flag,
  input wire logic        powerdown_flag
);
  logic       rst_ev;
  logic       wake_now;
  logic [9:0] need;
  logic [9:0] tick_cnt_r;
  // Wake is the only state out of reset with oscillators on but core and peripherals held
  assign rst_ev   = por_event | low_voltage_reset | ~reset_pin_n | wdt_timeout_reset;
  assign wake_now = losc_en & ~periph_en & ~core_reset;
  assign need     = any_crystal_mode ? WAKE_XTAL_CYC : WAKE_RC_CYC;
  // Ticks seen during wake, cleared while halted
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 10'h000;
    end else begin
      tick_cnt_r <= !losc_en ? 10'h000 : tick_cnt_r + {9'h000, fosc_tick & wake_now};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_halt_entry: assert property (sleep_instr && cpu_run && !rst_ev |=> !cpu_run && !losc_en && wdt_restart && timeout_flag && !powerdown_flag)
    else $error("halt entry outputs wrong");
  a_halt_off: assert property (!losc_en |-> !cpu_run && !periph_en && !timer_allow && !hosc_en)
    else $error("something runs in halt");
  a_halt_sources: assert property (!losc_en && !wdt_timeout_irq && !port_change_irq && external_irq_inputs == 2'h0 && !rst_ev |=> !losc_en)
    else $error("halt left without wake source");
  a_stby_wake: assert property (periph_en && !cpu_run && (port_change_irq || timer_irq) && !rst_ev |=> cpu_run)
    else $error("standby wake delayed");
  a_resume_kind: assert property (resume_isr || resume_next |-> cpu_run && !(resume_isr && resume_next) && isr_addr == ISR_VECTOR)
    else $error("resume pulse wrong");
  a_clear_flags: assert property (watchdog_clear_instruction && !sleep_instr && !rst_ev |=> timeout_flag && powerdown_flag)
    else $error("watchdog clear flags wrong");
  a_supply_flags: assert property ((por_event || low_voltage_reset) && !wdt_timeout_reset |=> core_reset && timeout_flag && powerdown_flag)
    else $error("supply reset flags wrong");
  a_rst_hold: assert property (rst_ev |=> core_reset && !cpu_run)
    else $error("reset event not held");
  a_wake_count: assert property ((resume_isr || resume_next) && $past(wake_now) |-> tick_cnt_r >= need && tick_cnt_r <= need + 10'h001)
    else $error("wake delay count wrong");
endmodule
bind hwrs_seq hwrs_monitor i_hwrs_monitor (.clock, .nrst, .sleep_instr, .watchdog_clear_instruction, .por_event,
  .low_voltage_reset, .reset_pin_n, .wdt_timeout_reset, .wdt_timeout_irq, .port_change_irq, .external_irq_inputs,
  .timer_irq, .any_crystal_mode, .fosc_tick, .core_reset, .cpu_run, .periph_en, .timer_allow, .hosc_en, .losc_en,
  .wdt_restart, .resume_isr, .resume_next, .isr_addr, .timeout_flag, .powerdown_flag);

// [test/hwrs_osc_model.sv]
`timescale 1ns/1ps
module hwrs_osc_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       osc_on,
  input  wire logic [1:0] div_sel,
  output logic            fosc_tick
);
  logic [1:0] cnt_r;
  // Stopped oscillator gives no ticks, so a wake count cannot creep on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r     <= 2'h0;
      fosc_tick <= 1'b0;
    end else begin
      cnt_r     <= (!osc_on || cnt_r >= div_sel) ? 2'h0 : cnt_r + 2'h1;
      fosc_tick <= osc_on && cnt_r >= div_sel;
    end
  end
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  import hwrs_pkg::*;
  localparam logic [21:0] PW [0:4] = '{22'h000014, 22'h00001E, 22'h000028, 22'h000032, 22'h00003C};
  localparam logic [3:0]  FT [0:3] = '{4'h5, 4'h1, 4'hB, 4'hC};
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, sleep_instr, watchdog_clear_instruction;
  logic global_irq_enable, por_event, low_voltage_reset, reset_pin_n, wdt_timeout_reset, wdt_timeout_irq;
  logic port_change_irq, timer_irq, low_voltage_detect, any_crystal_mode, startup_fast, fosc_tick;
  logic core_reset, cpu_run, periph_en, timer_allow, hosc_en, losc_en, normal_mode, wdt_restart;
  logic resume_isr, resume_next, timeout_flag, powerdown_flag, er;
  logic [1:0]  external_irq_inputs, div_sel;
  logic [2:0]  pwrup_sel;
  logic [7:0]  paddr;
  logic [11:0] isr_addr;
  logic [31:0] pwdata, prdata, rd, seed;
  int          failures, n_tests, n, osc_startup_wait;
  hwrs_seq #(.PWRUP_CYC_0(PW[0]), .PWRUP_CYC_1(PW[1]), .PWRUP_CYC_2(PW[2]), .PWRUP_CYC_3(PW[3]),
    .PWRUP_CYC_4(PW[4])) i_hwrs_seq (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_instr, .watchdog_clear_instruction, .global_irq_enable, .por_event, .low_voltage_reset,
    .reset_pin_n, .wdt_timeout_reset, .wdt_timeout_irq, .port_change_irq, .external_irq_inputs, .timer_irq,
    .low_voltage_detect, .any_crystal_mode, .pwrup_sel, .startup_fast, .fosc_tick, .core_reset, .cpu_run,
    .periph_en, .timer_allow, .hosc_en, .losc_en, .normal_mode, .wdt_restart, .resume_isr, .resume_next,
    .isr_addr, .timeout_flag, .powerdown_flag);
  hwrs_osc_model i_hwrs_osc_model (.clock, .nrst, .osc_on(hosc_en | losc_en), .div_sel, .fosc_tick);
  // Clock of 100 ns period
  always #50 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h got %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reads sample right after the edge, so they see what the edge sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_run();
    n = 0;
    do begin @(posedge clock); n++; end while (cpu_run !== 1'b1 && n < 3000);
  endtask
  task automatic rst_event(input int k);
    case (k)
      0: por_event <= 1'b1;
      1: low_voltage_reset <= 1'b1;
      2: reset_pin_n <= 1'b0;
      default: wdt_timeout_reset <= 1'b1;
    endcase
    repeat (3) @(posedge clock);
    por_event <= 1'b0; low_voltage_reset <= 1'b0; reset_pin_n <= 1'b1; wdt_timeout_reset <= 1'b0;
    wait_run();
  endtask
  task automatic go_halt();
    sleep_instr <= 1'b1;
    @(posedge clock);
    sleep_instr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // Hang guard, well beyond the longest expected run
  initial begin
    #3000000;
    failures++;
    print_verdict();
  end
  initial begin
    clock = 0; nrst = 0; seed = 32'h00001DF6; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 0;
    sleep_instr = 0; watchdog_clear_instruction = 0; global_irq_enable = 0; por_event = 0; low_voltage_reset = 0;
    reset_pin_n = 1; wdt_timeout_reset = 0; wdt_timeout_irq = 0; port_change_irq = 0; external_irq_inputs = 2'h0;
    timer_irq = 0; low_voltage_detect = 0; any_crystal_mode = 0; pwrup_sel = 3'h0; startup_fast = 1; div_sel = 2'h1;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    wait_run();
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("stat", 32'h00000818, rd);
    apb(1'b1, ADDR_STAT, 32'hFFFFFFFF);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h00000001, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    // Every delay code, plus an out-of-range code, with random start mode
    for (int k = 0; k < 6; k++) begin
      pwrup_sel <= (k == 5) ? 3'h7 : 3'(k);
      startup_fast <= 1'(rnd());
      div_sel <= 2'(rnd() % 3);
      osc_startup_wait = (k == 0) ? OST_SHORT_CYC : OST_LONG_CYC;
      @(posedge clock);
      rst_event(k & 1);
      chk("pwrup", 1, n >= PW[k > 4 ? 4 : k] + osc_startup_wait && n <= PW[k > 4 ? 4 : k] + osc_startup_wait * (div_sel + 1) + div_sel + 8);
      chk("start mode", {31'h0, startup_fast}, {31'h0, normal_mode});
      chk("supply flags", 32'h3, {30'h0, timeout_flag, powerdown_flag});
    end
    startup_fast <= 1'b1;
    rst_event(0);
    // Halt by instruction, one wake source each, timer and low-voltage ignored
    for (int w = 0; w < 4; w++) begin
      global_irq_enable <= 1'(rnd());
      any_crystal_mode <= (w == 3);
      div_sel <= 2'(rnd() % 3);
      go_halt();
      chk("halt flags", 32'h2, {30'h0, timeout_flag, powerdown_flag});
      chk("halt off", 32'h0, {29'h0, cpu_run, losc_en, hosc_en});
      timer_irq <= 1'b1; low_voltage_detect <= 1'b1;
      repeat (3) @(posedge clock);
      timer_irq <= 1'b0; low_voltage_detect <= 1'b0;
      chk("no wake", 32'h0, {31'h0, losc_en});
      case (w)
        0: wdt_timeout_irq <= 1'b1;
        1: port_change_irq <= 1'b1;
        default: external_irq_inputs <= 2'(w - 1);
      endcase
      @(posedge clock);
      wdt_timeout_irq <= 1'b0; port_change_irq <= 1'b0; external_irq_inputs <= 2'h0;
      wait_run();
      chk("wake time", 1, n >= (w == 3 ? WAKE_XTAL_CYC : WAKE_RC_CYC));
      chk("resume", {30'h0, global_irq_enable, !global_irq_enable}, {30'h0, resume_isr, resume_next});
      chk("normal", 32'h1, {31'h0, normal_mode});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("mode back", 32'h1, rd);
    end
    // Slow first, never in the halt write itself
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h6);
    repeat (2) @(posedge clock);
    chk("mode halt", 32'h0, {31'h0, losc_en});
    port_change_irq <= 1'b1;
    @(posedge clock);
    port_change_irq <= 1'b0;
    wait_run();
    chk("slow resume", 32'h0, {30'h0, normal_mode, hosc_en});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("stop kept", 32'h2, rd);
    apb(1'b1, ADDR_CTRL, 32'h8);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("standby", 32'h00001010, rd);
    timer_irq <= 1'b1;
    @(posedge clock);
    timer_irq <= 1'b0;
    @(posedge clock);
    chk("stby wake", 32'h1, {31'h0, cpu_run});
    // Pin and watchdog resets inside and outside halt
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        watchdog_clear_instruction <= 1'b1;
        @(posedge clock);
        watchdog_clear_instruction <= 1'b0;
        @(posedge clock);
        chk("clear", 32'h3, {30'h0, timeout_flag, powerdown_flag});
      end
      if (FT[i][3]) go_halt();
      rst_event(FT[i][2] ? 3 : 2);
      chk("event flags", {30'h0, FT[i][1:0]}, {30'h0, timeout_flag, powerdown_flag});
    end
    print_verdict();
  end
endmodule
